// ### tc2_pkg.sv
// Package: register map, field layout, modes and state carrier for timer 2
package tc2_pkg;

   // ==========================================================
   // Register byte offsets on APB
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_MODE    = 8'h04;
   localparam logic [7:0] OFS_COUNT   = 8'h08;
   localparam logic [7:0] OFS_CAPREL  = 8'h0C;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_MASK    = 8'h14;

   // ==========================================================
   // Control register bit positions
   localparam int BIT_OVERFLOW = 7;
   localparam int BIT_EXTERNAL = 6;
   localparam int BIT_RX_CLK   = 5;
   localparam int BIT_TX_CLK   = 4;
   localparam int BIT_EXT_EN   = 3;
   localparam int BIT_RUN      = 2;
   localparam int BIT_COUNTER  = 1;
   localparam int BIT_CAPTURE  = 0;

   // Mode register bit positions
   localparam int BIT_DOWN_EN  = 0;
   localparam int BIT_SIX_CLK  = 1;

   // Interrupt status bit positions
   localparam int IRQ_OVERFLOW = 0;
   localparam int IRQ_EXTERNAL = 1;

   // ==========================================================
   // Reset values and counter constants
   localparam logic [7:0]  RST_CONTROL = 8'h00;
   localparam logic [1:0]  RST_MODE    = 2'h0;
   localparam logic [15:0] COUNT_TOP   = 16'hFFFF;
   localparam logic [15:0] COUNT_ONE   = 16'h0001;

   // ==========================================================
   // Tick rates in oscillator cycles
   localparam logic [3:0] MACH_DIV_SIX    = 4'h6;
   localparam logic [3:0] MACH_DIV_TWELVE = 4'hC;
   localparam logic [3:0] BAUD_DIV_SIX    = 4'h1;
   localparam logic [3:0] BAUD_DIV_TWELVE = 4'h2;

   // ==========================================================
   // Operating modes
   typedef enum logic [1:0] {
      TC2_OFF,
      TC2_AUTO,
      TC2_CAPTURE,
      TC2_BAUD
   } tc2_mode_t;

   // Whole state of the timer top
   typedef struct packed {
      logic [7:0]  control;
      logic [1:0]  mode;
      logic [15:0] count;
      logic [15:0] caprel;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic        baud_pulse;
      logic        rx_use;
      logic        tx_use;
   } tc2_state_t;

   // Mode decode from run, serial selects and capture select
   function automatic tc2_mode_t tc2_decode(input logic [7:0] c);
      if (!c[BIT_RUN])
         return TC2_OFF;
      else if (c[BIT_RX_CLK] | c[BIT_TX_CLK])
         return TC2_BAUD;
      else if (c[BIT_CAPTURE])
         return TC2_CAPTURE;
      else
         return TC2_AUTO;
   endfunction

endpackage

// ### tc2_sync_edge.sv
// Two-stage pin synchroniser with falling edge pulse
`timescale 1ns/1ns
module tc2_sync_edge (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin,
   output logic      level,
   output logic      fall
);

   // ==========================================================
   // Synchroniser
   logic meta;
   logic prev;

   // Stage one feeds only stage two; pins idle high
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta  <= 1'b1;
         level <= 1'b1;
         prev  <= 1'b1;
      end else begin
         meta  <= pin;
         level <= meta;
         prev  <= level;
      end
   end

   // One-cycle pulse on a 1-to-0 transition
   assign fall = prev & ~level;

endmodule

// ### tc2_tick_div.sv
// Machine-cycle and baud-rate tick dividers
`timescale 1ns/1ns
module tc2_tick_div (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic six_clock,
   output logic      mach_tick,
   output logic      baud_tick
);

   // ==========================================================
   // Dividers
   logic [3:0] mach_cnt;
   logic [3:0] baud_cnt;
   logic [3:0] mach_div;
   logic [3:0] baud_div;

   // Wrap test shared by both dividers
   function automatic logic at_end(input logic [3:0] c,
                                   input logic [3:0] d);
      return c >= (d - 4'h1);
   endfunction

   assign mach_div = six_clock ? tc2_pkg::MACH_DIV_SIX
                               : tc2_pkg::MACH_DIV_TWELVE;
   assign baud_div = six_clock ? tc2_pkg::BAUD_DIV_SIX
                               : tc2_pkg::BAUD_DIV_TWELVE;

   // Mode switch mid-period shortens (twelve to six) or stretches (six to twelve) one period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mach_cnt  <= 4'h0;
         baud_cnt  <= 4'h0;
         mach_tick <= 1'b0;
         baud_tick <= 1'b0;
      end else begin
         mach_tick <= at_end(mach_cnt, mach_div);
         baud_tick <= at_end(baud_cnt, baud_div);
         mach_cnt  <= at_end(mach_cnt, mach_div) ? 4'h0 : mach_cnt + 4'h1;
         baud_cnt  <= at_end(baud_cnt, baud_div) ? 4'h0 : baud_cnt + 4'h1;
      end
   end

endmodule

// ### tc2_timer.sv
// Timer 2 top: 16-bit capture, auto-reload and baud-rate timer on APB
//
// Summary of operation
// - 16-bit counter on machine ticks (baud ticks in baud mode) or count pin, by counter select
// - Mode from serial selects, capture select and run bit; run 0 stops
// - Capture mode, external enable clear: plain timer, overflow sets flag
// - Capture mode, external enable set: trigger falling edge copies count, sets external flag
// - Both flags share one interrupt; software reads both to tell apart
// - Capture mode never reloads; timer ticks at osc/6 or osc/12
// - Reset clears down-count enable; when set in auto-reload mode, trigger picks direction
// - Auto-reload up: overflow past FFFF sets flag and reloads count
// - Auto-reload with external enable: trigger fall reloads, sets flag
// - Up/down with trigger high: count up, overflow sets flag, reloads
// - Up/down with trigger low: down to reload value, flag, load FFFF
// - Up/down mode toggles external flag on wraps, no interrupt from it
// - Receive clock select routes timer overflow to serial receive clock
// - Transmit clock select routes timer overflow to serial transmit
// - Baud mode rollover reloads count without flag or interrupt
// - Baud mode with external enable: trigger fall sets external flag without reload
`timescale 1ns/1ns
module tc2_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        count_pin,
   input  wire logic        trigger_input,
   output logic             irq,
   output logic             baud_overflow,
   output logic             rx_clock_select,
   output logic             tx_clock_select
);

   // ==========================================================
   // Pin synchronisers and tick dividers
   logic cnt_level;
   logic cnt_fall;
   logic trg_level;
   logic trg_fall;
   logic mach_tick;
   logic baud_tick;

   tc2_pkg::tc2_state_t s;
   tc2_pkg::tc2_state_t next_s;

   tc2_sync_edge u_cnt_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (count_pin),
      .level   (cnt_level),
      .fall    (cnt_fall)
   );

   tc2_sync_edge u_trg_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (trigger_input),
      .level   (trg_level),
      .fall    (trg_fall)
   );

   tc2_tick_div u_div (
      .pclk      (pclk),
      .presetn   (presetn),
      .six_clock (s.mode[tc2_pkg::BIT_SIX_CLK]),
      .mach_tick (mach_tick),
      .baud_tick (baud_tick)
   );

   // ==========================================================
   // Event decode
   tc2_pkg::tc2_mode_t mode;
   logic step;
   logic updown;
   logic count_up;
   logic wrap_up;
   logic wrap_dn;
   logic ext_edge;
   logic set_ovf;
   logic set_ext;
   logic tog_ext;
   logic reload;
   logic setup;
   logic access;
   logic mapped;
   logic [31:0] rd_value;

   // Count source and wrap detection
   always_comb begin
      mode     = tc2_pkg::tc2_decode(s.control);
      step     = (mode != tc2_pkg::TC2_OFF) &
                 (s.control[tc2_pkg::BIT_COUNTER] ? cnt_fall :
                  (mode == tc2_pkg::TC2_BAUD) ? baud_tick : mach_tick);
      updown   = (mode == tc2_pkg::TC2_AUTO) &
                 s.mode[tc2_pkg::BIT_DOWN_EN];
      count_up = ~updown | trg_level;
      wrap_up  = step & count_up & (s.count == tc2_pkg::COUNT_TOP);
      wrap_dn  = step & ~count_up & (s.count == s.caprel);
      ext_edge = trg_fall & s.control[tc2_pkg::BIT_EXT_EN] &
                 (mode != tc2_pkg::TC2_OFF) & ~updown;
      // baud rollover raises no overflow flag
      set_ovf  = (wrap_up | wrap_dn) & (mode != tc2_pkg::TC2_BAUD);
      set_ext  = ext_edge;
      // toggle instead of interrupt in up/down mode
      tog_ext  = updown & (wrap_up | wrap_dn);
      // trigger reload in plain auto-reload only
      reload   = (mode == tc2_pkg::TC2_AUTO) & ~updown & ext_edge;
   end

   // APB phase and address decode
   always_comb begin
      setup  = psel & ~penable;
      access = psel & penable & s.pready;
      mapped = 1'b1;
      case (paddr)
         tc2_pkg::OFS_CONTROL: rd_value = {24'h00_0000, s.control};
         tc2_pkg::OFS_MODE:    rd_value = {30'h0000_0000, s.mode};
         tc2_pkg::OFS_COUNT:   rd_value = {16'h0000, s.count};
         tc2_pkg::OFS_CAPREL:  rd_value = {16'h0000, s.caprel};
         tc2_pkg::OFS_STATUS:  rd_value = {30'h0000_0000, s.status};
         tc2_pkg::OFS_MASK:    rd_value = {30'h0000_0000, s.mask};
         default: begin
            rd_value = 32'h0000_0000;
            mapped   = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_s            = s;
      next_s.pready     = setup;
      next_s.pslverr    = setup & ~mapped;
      next_s.prdata     = setup ? rd_value : s.prdata;
      next_s.baud_pulse = 1'b0;

      // Counter update per mode
      case (mode)
         tc2_pkg::TC2_CAPTURE: begin
            if (step)
               next_s.count = s.count + tc2_pkg::COUNT_ONE;
            if (ext_edge)
               next_s.caprel = s.count;
         end
         tc2_pkg::TC2_AUTO: begin
            if (wrap_up | reload)
               next_s.count = s.caprel;
            else if (wrap_dn)
               next_s.count = tc2_pkg::COUNT_TOP;
            else if (step & count_up)
               next_s.count = s.count + tc2_pkg::COUNT_ONE;
            else if (step)
               next_s.count = s.count - tc2_pkg::COUNT_ONE;
         end
         tc2_pkg::TC2_BAUD: begin
            // rollover reloads and clocks serial port
            if (wrap_up) begin
               next_s.count      = s.caprel;
               next_s.baud_pulse = 1'b1;
            end else if (step) begin
               next_s.count = s.count + tc2_pkg::COUNT_ONE;
            end
         end
         default: begin
            next_s.count = s.count;
         end
      endcase

      // Software writes at the access edge win over counting
      if (access & pwrite) begin
         case (paddr)
            tc2_pkg::OFS_CONTROL: next_s.control = pwdata[7:0];
            tc2_pkg::OFS_MODE:    next_s.mode    = pwdata[1:0];
            tc2_pkg::OFS_COUNT:   next_s.count   = pwdata[15:0];
            tc2_pkg::OFS_CAPREL:  next_s.caprel  = pwdata[15:0];
            tc2_pkg::OFS_MASK:    next_s.mask    = pwdata[1:0];
            default:              next_s.mask    = next_s.mask;
         endcase
      end

      // hardware sets flags, up/down mode toggles external flag; set beats a same-cycle clear
      if (set_ovf)
         next_s.control[tc2_pkg::BIT_OVERFLOW] = 1'b1;
      if (set_ext)
         next_s.control[tc2_pkg::BIT_EXTERNAL] = 1'b1;
      if (tog_ext)
         next_s.control[tc2_pkg::BIT_EXTERNAL] =
            ~s.control[tc2_pkg::BIT_EXTERNAL];

      // Sticky status, cleared by read, new events win
      if (access & ~pwrite & (paddr == tc2_pkg::OFS_STATUS))
         next_s.status = 2'b00;
      if (set_ovf)
         next_s.status[tc2_pkg::IRQ_OVERFLOW] = 1'b1;
      if (set_ext)
         next_s.status[tc2_pkg::IRQ_EXTERNAL] = 1'b1;

      // one shared interrupt for both causes
      next_s.irq    = |(next_s.status & next_s.mask);
      next_s.rx_use = next_s.control[tc2_pkg::BIT_RX_CLK];
      next_s.tx_use = next_s.control[tc2_pkg::BIT_TX_CLK];
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s         <= '0;
         s.control <= tc2_pkg::RST_CONTROL;
         s.mode    <= tc2_pkg::RST_MODE;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from state flops
   assign prdata          = s.prdata;
   assign pready          = s.pready;
   assign pslverr         = s.pslverr;
   assign irq             = s.irq;
   assign baud_overflow   = s.baud_pulse;
   assign rx_clock_select = s.rx_use;
   assign tx_clock_select = s.tx_use;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic cnt_wr;
   assign cnt_wr = access & pwrite & (paddr == tc2_pkg::OFS_COUNT);

   hold_stop_a: assert property (
      (mode == tc2_pkg::TC2_OFF) & ~cnt_wr |=> $stable(s.count))
      else $error("stopped timer count moved");

   ovf_flag_a: assert property (
      (mode == tc2_pkg::TC2_CAPTURE) & wrap_up & ~cnt_wr
      |=> s.control[tc2_pkg::BIT_OVERFLOW] && s.count == 16'h0000)
      else $error("capture overflow lost");

   reload_up_a: assert property (
      (mode == tc2_pkg::TC2_AUTO) & wrap_up & ~cnt_wr
      |=> s.count == $past(s.caprel))
      else $error("auto reload missing");

   capture_val_a: assert property (
      (mode == tc2_pkg::TC2_CAPTURE) & ext_edge & ~access
      |=> s.caprel == $past(s.count)
          && s.control[tc2_pkg::BIT_EXTERNAL])
      else $error("capture value wrong");

   under_load_a: assert property (
      wrap_dn & ~cnt_wr |=> s.count == 16'hFFFF)
      else $error("underflow did not load top");

   ext_toggle_a: assert property (
      tog_ext & ~access |=> s.control[tc2_pkg::BIT_EXTERNAL]
         != $past(s.control[tc2_pkg::BIT_EXTERNAL]) && !$rose(s.status[1]))
      else $error("external flag toggle wrong");

   baud_quiet_a: assert property (
      (mode == tc2_pkg::TC2_BAUD) & wrap_up & ~access
      & ~s.control[tc2_pkg::BIT_OVERFLOW]
      |=> ~s.control[tc2_pkg::BIT_OVERFLOW] && baud_overflow)
      else $error("baud rollover misbehaved");

   irq_shared_a: assert property (
      ((set_ovf & s.mask[tc2_pkg::IRQ_OVERFLOW])
       | (set_ext & s.mask[tc2_pkg::IRQ_EXTERNAL]))
      & ~(access & pwrite) |=> irq)
      else $error("interrupt not raised");

   route_sel_a: assert property (
      s.control[tc2_pkg::BIT_RX_CLK] & ~access |=> rx_clock_select)
      else $error("receive clock route wrong");

   tx_route_a: assert property (
      s.control[tc2_pkg::BIT_TX_CLK] & ~access |=> tx_clock_select)
      else $error("transmit clock route wrong");

   trig_reload_a: assert property (
      reload & ~cnt_wr |=> s.count == $past(s.caprel)
          && s.control[tc2_pkg::BIT_EXTERNAL])
      else $error("trigger reload missing");

   baud_ext_a: assert property (
      (mode == tc2_pkg::TC2_BAUD) & ext_edge & ~wrap_up & ~cnt_wr
      |=> s.control[tc2_pkg::BIT_EXTERNAL]
          && (s.count == $past(s.count)
              || s.count == $past(s.count) + 16'h0001))
      else $error("baud trigger reloaded count");

endmodule

// ### tc2_far_side.sv
// Far side model: trigger and count pins, serial port baud clock user
`timescale 1ns/1ns
module tc2_far_side (
   input  wire logic pclk,
   input  wire logic baud_overflow,
   output logic      trigger_input,
   output logic      count_pin,
   output int        baud_seen
);
   // ==========================================================
   // Pins idle high, so the synchroniser sees no false edge
   initial begin
      trigger_input = 1'b1;
      count_pin     = 1'b1;
      baud_seen     = 0;
   end

   // serial clock use
   // Serial port counts each rollover pulse it is handed
   always @(posedge pclk) begin
      if (baud_overflow === 1'b1)
         baud_seen <= baud_seen + 1;
   end

   // Trigger level; held low it also picks down counting
   task automatic set_trigger(input logic v);
      @(posedge pclk);
      trigger_input <= v;
   endtask

   // Count pulses wide enough for the two stage synchroniser
   task automatic pulse_count(input int n);
      repeat (n) begin
         @(posedge pclk);
         count_pin <= 1'b0;
         repeat (4) @(posedge pclk);
         count_pin <= 1'b1;
         repeat (4) @(posedge pclk);
      end
   endtask
endmodule

// ### tc2_timer_tb_top.sv
// Testbench: scenario tasks driving timer 2 over APB
`timescale 1ns/1ns
module tc2_timer_tb_top;
   // ==========================================================
   // Short register addresses
   localparam logic [7:0] CTL = tc2_pkg::OFS_CONTROL;
   localparam logic [7:0] MOD = tc2_pkg::OFS_MODE;
   localparam logic [7:0] CNT = tc2_pkg::OFS_COUNT;
   localparam logic [7:0] CAP = tc2_pkg::OFS_CAPREL;
   localparam logic [7:0] STA = tc2_pkg::OFS_STATUS;
   localparam logic [7:0] MSK = tc2_pkg::OFS_MASK;

   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        baud_ovf;
   logic        rx_sel;
   logic        tx_sel;
   logic        trig;
   logic        cnt_pin;
   int          baud_seen;
   int          fails;
   int          check_count;
   logic [31:0] rd;
   logic        err;

   tc2_timer u_dut (
      .pclk            (pclk),
      .presetn         (presetn),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .count_pin       (cnt_pin),
      .trigger_input   (trig),
      .irq             (irq),
      .baud_overflow   (baud_ovf),
      .rx_clock_select (rx_sel),
      .tx_clock_select (tx_sel)
   );

   tc2_far_side u_far (
      .pclk          (pclk),
      .baud_overflow (baud_ovf),
      .trigger_input (trig),
      .count_pin     (cnt_pin),
      .baud_seen     (baud_seen)
   );

   // ==========================================================
   // Clock, 40 ns period
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask

   // APB transfer; held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         fails++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
   endtask

   // Bounded wait on the interrupt level
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      while (irq !== v && n < 300) begin
         @(posedge pclk);
         n++;
      end
      chk("irq", {31'h0, v}, {31'h0, irq});
      if (n >= 300)
         test_done();
   endtask

   // ==========================================================
   // Reset values, unmapped address
   task automatic s_reset();
      rchk("control", CTL, 32'h0000_0000);
      rchk("mode", MOD, 32'h0000_0000);
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, {31'h0, err});
   endtask

   // Auto-reload up, flag handling, trigger reload
   task automatic s_auto();
      wr(MSK, 32'h0000_0001);
      wr(CAP, 32'h0000_FFF0);
      wr(CNT, 32'h0000_FFFF);
      wr(CTL, 32'h0000_0004);
      wait_irq(1'b1);
      rchk("overflow", CTL, 32'h0000_0084);
      apb(1'b0, CNT, 32'h0000_0000);
      chk("reload", 32'h0000_7FF8, {17'h0, rd[15:1]});
      wr(CTL, 32'h0000_0080);
      rchk("status", STA, 32'h0000_0001);
      rchk("status clr", STA, 32'h0000_0000);
      wait_irq(1'b0);
      rchk("flag kept", CTL, 32'h0000_0080);
      wr(CTL, 32'h0000_0000);
      rchk("flag clr", CTL, 32'h0000_0000);
      // Trigger fall reloads with external enable
      wr(MSK, 32'h0000_0002);
      wr(CAP, 32'h0000_0100);
      wr(CNT, 32'h0000_5000);
      wr(CTL, 32'h0000_000C);
      u_far.set_trigger(1'b0);
      wait_irq(1'b1);
      rchk("ext flag", CTL, 32'h0000_004C);
      apb(1'b0, CNT, 32'h0000_0000);
      chk("trig reload", 32'h0000_0080, {17'h0, rd[15:1]});
      u_far.set_trigger(1'b1);
      wr(CTL, 32'h0000_0000);
      rchk("status", STA, 32'h0000_0002);
   endtask

   // Capture keeps counting, no reload
   task automatic s_capture();
      // Plain capture timer overflow: flag set, count wraps to zero
      wr(MSK, 32'h0000_0003);
      wr(CNT, 32'h0000_FFFF);
      wr(CTL, 32'h0000_0005);
      wait_irq(1'b1);
      rchk("capture ovf", CTL, 32'h0000_0085);
      apb(1'b0, CNT, 32'h0000_0000);
      chk("no reload", 32'h0, {17'h0, rd[15:1]});
      rchk("ovf status", STA, 32'h0000_0001);
      wr(CTL, 32'h0000_0000);
      wr(CNT, 32'h0000_1234);
      wr(CAP, 32'h0000_0000);
      wr(CTL, 32'h0000_000D);
      u_far.set_trigger(1'b0);
      wait_irq(1'b1);
      apb(1'b0, CAP, 32'h0000_0000);
      chk("captured", 32'h0000_091A, {17'h0, rd[15:1]});
      rchk("ext flag", CTL, 32'h0000_004D);
      repeat (30) @(posedge pclk);
      apb(1'b0, CNT, 32'h0000_0000);
      chk("runs on", 32'h1, {31'h0, rd[15:0] > 16'h1235});
      u_far.set_trigger(1'b1);
      wr(CTL, 32'h0000_0000);
      rchk("status", STA, 32'h0000_0002);
   endtask

   // Tick rate in both clock modes, count held when stopped
   task automatic s_rate();
      int          dv;
      logic [31:0] c;
      for (int m = 0; m < 2; m++) begin
         dv = (m == 1) ? 6 : 12;
         wr(MOD, {30'h0, m[0], 1'b0});
         wr(CNT, 32'h0000_0000);
         wr(CTL, 32'h0000_0004);
         repeat (117) @(posedge pclk);
         wr(CTL, 32'h0000_0000);
         apb(1'b0, CNT, 32'h0000_0000);
         c = rd;
         chk("rate", 32'h1, {31'h0, c >= 120 / dv - 1 && c <= 120 / dv + 1});
         repeat (30) @(posedge pclk);
         rchk("held", CNT, c);
      end
      wr(MOD, 32'h0000_0000);
   endtask

   // Up/down counting, toggled external flag
   task automatic s_updown();
      wr(MOD, 32'h0000_0001);
      wr(MSK, 32'h0000_0003);
      wr(CAP, 32'h0000_0010);
      wr(CNT, 32'h0000_0012);
      u_far.set_trigger(1'b0);
      wr(CTL, 32'h0000_0004);
      wait_irq(1'b1);
      rchk("underflow", CTL, 32'h0000_00C4);
      apb(1'b0, CNT, 32'h0000_0000);
      chk("load top", 32'h0000_7FFF, {17'h0, rd[15:1]});
      rchk("no ext irq", STA, 32'h0000_0001);
      u_far.set_trigger(1'b1);
      wr(CTL, 32'h0000_0004);
      wait_irq(1'b1);
      rchk("overflow", CTL, 32'h0000_00C4);
      apb(1'b0, CNT, 32'h0000_0000);
      chk("reload", 32'h0000_0008, {17'h0, rd[15:1]});
      wr(CTL, 32'h0000_0000);
      wr(MOD, 32'h0000_0000);
      rchk("status", STA, 32'h0000_0001);
   endtask

   // Baud mode: rollovers out, no overflow flag
   task automatic s_baud();
      logic [7:0] cv [3];
      int         b0;
      cv = '{8'h24, 8'h14, 8'h34};
      foreach (cv[i]) begin
         wr(CTL, {24'h0, cv[i]});
         repeat (2) @(posedge pclk);
         chk("clk sel", {30'h0, cv[i][5:4]}, {30'h0, rx_sel, tx_sel});
      end
      wr(CAP, 32'h0000_FFF0);
      wr(CNT, 32'h0000_FFF0);
      b0 = baud_seen;
      wr(CTL, 32'h0000_003C);
      repeat (200) @(posedge pclk);
      chk("rollovers", 32'h1, {31'h0, baud_seen - b0 >= 4});
      chk("no irq", 32'h0, {31'h0, irq});
      rchk("no flag", CTL, 32'h0000_003C);
      u_far.set_trigger(1'b0);
      wait_irq(1'b1);
      rchk("ext flag", CTL, 32'h0000_007C);
      u_far.set_trigger(1'b1);
      wr(CTL, 32'h0000_0000);
      rchk("status", STA, 32'h0000_0002);
   endtask

   // Counter mode counts pin falls only
   task automatic s_counter();
      wr(CNT, 32'h0000_0000);
      wr(CTL, 32'h0000_0006);
      u_far.pulse_count(5);
      repeat (6) @(posedge pclk);
      wr(CTL, 32'h0000_0002);
      rchk("events", CNT, 32'h0000_0005);
   endtask

   // Mid-run reset brings mode and control back to defaults
   task automatic s_rerun();
      wr(MOD, 32'h0000_0001);
      wr(CTL, 32'h0000_0004);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("irq rst", 32'h0, {31'h0, irq});
      rchk("mode rst", MOD, 32'h0000_0000);
      rchk("ctl rst", CTL, 32'h0000_0000);
      rchk("cnt rst", CNT, 32'h0000_0000);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      presetn     = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 8'h00;
      pwdata      = 32'h0000_0000;
      fails       = 0;
      check_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      s_reset();
      s_auto();
      s_capture();
      s_rate();
      s_updown();
      s_baud();
      s_counter();
      s_rerun();
      test_done();
   end
endmodule
